/* verilog/dsw_pkg.sv */
package dsw_pkg;

    // Word width of every cyclic process data word
    localparam int unsigned WORD_W = 16;

    // Telegram numbers that change the block's behaviour
    localparam logic [9:0] TELEGRAM_STD20  = 10'h014;  // Standard telegram 20
    localparam logic [9:0] TELEGRAM_CMD350 = 10'h15E;  // Telegram carrying command word three
    localparam logic [9:0] TELEGRAM_FREE   = 10'h3E7;  // Free interconnection, no word-by-word map
    localparam logic [9:0] TELEGRAM_RESET  = 10'h001;  // Selection assumed before the first clock

    // Status word one bit positions
    localparam int unsigned ST_READY_TO_START = 0;
    localparam int unsigned ST_READY          = 1;
    localparam int unsigned ST_OP_ENABLED     = 2;
    localparam int unsigned ST_FAULT          = 3;
    localparam int unsigned ST_NO_COAST_STOP  = 4;
    localparam int unsigned ST_NO_QUICK_STOP  = 5;
    localparam int unsigned ST_LOCKOUT        = 6;
    localparam int unsigned ST_ALARM          = 7;
    localparam int unsigned ST_SPEED_IN_TOL   = 8;
    localparam int unsigned ST_MASTER_REQ     = 9;
    localparam int unsigned ST_SPEED_REACHED  = 10;
    localparam int unsigned ST_LIMIT_REACHED  = 11;
    localparam int unsigned ST_BRAKE_OPEN     = 12;
    localparam int unsigned ST_NO_MOTOR_HOT   = 13;
    localparam int unsigned ST_CLOCKWISE      = 14;
    localparam int unsigned ST_BIT15          = 15;

    // Command word three field positions
    localparam int unsigned CW_FIXED_SP_LSB   = 0;   // Four bits, 0 to 3
    localparam int unsigned CW_MOTOR_SET_LSB  = 4;   // Two bits, 4 and 5
    localparam int unsigned CW_TECH_CTRL      = 8;
    localparam int unsigned CW_DC_BRAKE       = 9;
    localparam int unsigned CW_DROOP          = 11;
    localparam int unsigned CW_TORQUE_MODE    = 12;
    localparam int unsigned CW_NO_EXT_FAULT_N = 13;  // Active low external fault
    localparam int unsigned CW_CMD_SET_HI     = 15;

    // Status word value held until the first exchange
    localparam logic [WORD_W-1:0] STATUS_RESET = 16'h0000;

    // Drive state flags sampled into status word one
    typedef struct packed {
        logic power_on;
        logic electronics_ready;
        logic pulses_locked;
        logic on_command;
        logic fault_pending;
        logic operation_enabled;
        logic coast_stop_active;
        logic quick_stop_active;
        logic lockout_active;
        logic alarm_active;
        logic master_request;
        logic current_reached;
        logic torque_reached;
        logic brake_open;
        logic motor_overtemp_alarm;
        logic inverter_overload_alarm;
        logic command_set_low;
    } dsw_flags_t;

    // Decoded connections of command word three
    typedef struct packed {
        logic [3:0] fixed_setpoint_select;
        logic [1:0] motor_set_select;
        logic       tech_ctrl_enable;
        logic       dc_brake_enable;
        logic       droop_enable;
        logic       torque_mode;
        logic       external_fault;
        logic       command_set_high;
    } dsw_cmd_t;

    // Connections after reset or after leaving telegram 350: all zero, no external fault
    localparam dsw_cmd_t CMD_RESET = '{
        fixed_setpoint_select: 4'h0,
        motor_set_select:      2'h0,
        tech_ctrl_enable:      1'b0,
        dc_brake_enable:       1'b0,
        droop_enable:          1'b0,
        torque_mode:           1'b0,
        external_fault:        1'b0,
        command_set_high:      1'b0
    };

endpackage : dsw_pkg

/* verilog/dsw_words.sv */
`timescale 1ns/1ps
// Overview of operation
// - Status bit 0 set when powered, electronics initialised and pulses locked.
// - Status bit 1 set when on command present and no fault.
// - Status bit 2 set while operation is enabled and no fault is pending; motor follows setpoint.
// - Status bit 3 shows pending fault; controller acknowledges it via word one.
// - Status bits 4 and 5 high when no coast stop, no quick stop.
// - Status bit 6 shows switch-on lockout; needs ramp stop then fresh on.
// - Status bit 7 shows alarm; motor keeps running, no acknowledge needed.
// - Status bit 8 set when setpoint minus actual speed lies within tolerance.
// - Status bit 9 requests the controller to take over drive control.
// - Status bit 10 set when actual speed reaches comparison speed.
// - Status bit 11 set when current or torque comparison value reached.
// - Status bit 12 high opens holding brake, low closes it.
// - Status bit 13 active low; cleared during motor overtemperature alarm.
// - Status bit 14 set for positive speed, cleared for negative speed.
// - Command bits 0 to 3 select one of sixteen fixed setpoints.
// - Command bits 4 and 5 select the motor data set.
// - Command bit 8 enables technology controller; bit 9 enables DC braking.
// - Command bit 11 enables speed controller droop, low inhibits it.
// - Command bit 12 selects torque control, low selects speed control.
// - Command bit 13 active low; zero raises an external fault.
// - Command bit 15 is upper bit of the command set selector.
// - Leaving telegram 350 clears all command connections, external fault forced inactive.
// - Status word one is sent once per exchange cycle, except free telegram 999; command word three is taken only in telegram 350.
module dsw_words (
    // Clock and reset
    input  wire logic                        clock,
    input  wire logic                        rst,
    // Telegram selection
    input  wire logic [9:0]                  telegram_select,
    // Cyclic telegram exchange
    input  wire logic                        exchange_strobe,
    input  wire logic [dsw_pkg::WORD_W-1:0]  drive_command_word_three_in,
    output logic      [dsw_pkg::WORD_W-1:0]  drive_status_word_one,
    output logic                             status_valid,
    // Drive state
    input  wire dsw_pkg::dsw_flags_t         drive_flags,
    input  wire logic signed [15:0]          speed_setpoint,
    input  wire logic signed [15:0]          speed_actual,
    input  wire logic        [15:0]          speed_tolerance,
    input  wire logic signed [15:0]          compare_speed,
    // Decoded command connections
    output dsw_pkg::dsw_cmd_t                command_out,
    output logic             [1:0]           command_set_select
);
    import dsw_pkg::*;

    logic [9:0]        prev_telegram;
    logic              clockwise;
    logic              leave_350;
    logic              word_mapped;
    logic signed [16:0] speed_diff;
    logic        [16:0] speed_diff_abs;
    logic              speed_in_tol;
    logic              speed_reached;
    logic [WORD_W-1:0] next_status;
    dsw_cmd_t          next_command;

    // Turn a received command word into its connections; unused bits never read
    function automatic dsw_cmd_t decode_command(input logic [WORD_W-1:0] word);
        dsw_cmd_t c;
        c                       = CMD_RESET;
        c.fixed_setpoint_select = word[CW_FIXED_SP_LSB +: 4];
        c.motor_set_select      = word[CW_MOTOR_SET_LSB +: 2];
        c.tech_ctrl_enable      = word[CW_TECH_CTRL];
        c.dc_brake_enable       = word[CW_DC_BRAKE];
        c.droop_enable          = word[CW_DROOP];
        c.torque_mode           = word[CW_TORQUE_MODE];
        c.external_fault        = ~word[CW_NO_EXT_FAULT_N];
        c.command_set_high      = word[CW_CMD_SET_HI];
        // Bits 6, 7, 10 and 14 have no destination
        return c;
    endfunction : decode_command

    // Telegram seen on the previous clock, to spot a change
    always_ff @(posedge clock) begin
        if (rst) begin
            prev_telegram <= TELEGRAM_RESET;
        end else begin
            prev_telegram <= telegram_select;
        end
    end

    // Change of telegram away from 350 and word-by-word mapping
    assign leave_350   = (prev_telegram == TELEGRAM_CMD350) && (telegram_select != TELEGRAM_CMD350);
    assign word_mapped = (telegram_select != TELEGRAM_FREE);

    // Speed window: setpoint minus actual speed against the tolerance band
    always_comb begin
        speed_diff     = 17'(speed_setpoint) - 17'(speed_actual);
        speed_diff_abs = speed_diff[16] ? 17'(-speed_diff) : speed_diff;
        speed_in_tol   = (speed_diff_abs <= {1'b0, speed_tolerance});
        speed_reached  = (speed_actual >= compare_speed);
    end

    // Rotation sense, held while actual speed is exactly zero
    always_ff @(posedge clock) begin
        if (rst) begin
            clockwise <= 1'b0;
        end else if (speed_actual > 16'sh0000) begin
            clockwise <= 1'b1;
        end else if (speed_actual < 16'sh0000) begin
            clockwise <= 1'b0;
        end
    end

    // Assemble status word one from the live drive state
    always_comb begin
        next_status = '0;
        next_status[ST_READY_TO_START] = drive_flags.power_on & drive_flags.electronics_ready
                                         & drive_flags.pulses_locked;
        next_status[ST_READY]          = drive_flags.on_command & ~drive_flags.fault_pending;
        next_status[ST_OP_ENABLED]     = drive_flags.operation_enabled
                                         & ~drive_flags.fault_pending;
        next_status[ST_FAULT]          = drive_flags.fault_pending;
        next_status[ST_NO_COAST_STOP]  = ~drive_flags.coast_stop_active;
        next_status[ST_NO_QUICK_STOP]  = ~drive_flags.quick_stop_active;
        next_status[ST_LOCKOUT]        = drive_flags.lockout_active;
        next_status[ST_ALARM]          = drive_flags.alarm_active;
        next_status[ST_SPEED_IN_TOL]   = speed_in_tol;
        next_status[ST_MASTER_REQ]     = drive_flags.master_request;
        next_status[ST_SPEED_REACHED]  = speed_reached;
        next_status[ST_LIMIT_REACHED]  = drive_flags.current_reached | drive_flags.torque_reached;
        next_status[ST_BRAKE_OPEN]     = drive_flags.brake_open;
        next_status[ST_NO_MOTOR_HOT]   = ~drive_flags.motor_overtemp_alarm;
        next_status[ST_CLOCKWISE]      = clockwise;
        if (telegram_select == TELEGRAM_STD20) begin
            next_status[ST_BIT15] = drive_flags.command_set_low;
        end else begin
            next_status[ST_BIT15] = ~drive_flags.inverter_overload_alarm;
        end
    end

    // Send side: latch the status word once per exchange cycle, except in free telegram 999
    always_ff @(posedge clock) begin
        if (rst) begin
            drive_status_word_one <= STATUS_RESET;
            status_valid          <= 1'b0;
        end else begin
            status_valid <= exchange_strobe & word_mapped;
            if (exchange_strobe && word_mapped) begin
                drive_status_word_one <= next_status;
            end
        end
    end

    // Next command connections: cleared on leaving 350, captured only inside 350
    always_comb begin
        next_command = command_out;
        if (leave_350) begin
            next_command = CMD_RESET;
        end else if (exchange_strobe && telegram_select == TELEGRAM_CMD350) begin
            next_command = decode_command(drive_command_word_three_in);
        end
    end

    // Receive side: hold the decoded connections
    always_ff @(posedge clock) begin
        if (rst) begin
            command_out <= CMD_RESET;
        end else begin
            command_out <= next_command;
        end
    end

    // Full command set selector: upper bit from word three, lower from word one
    always_ff @(posedge clock) begin
        if (rst) begin
            command_set_select <= 2'h0;
        end else begin
            command_set_select <= {next_command.command_set_high, drive_flags.command_set_low};
        end
    end

endmodule : dsw_words

/* testbench/dsw_words_asserts.sv */
`timescale 1ns/1ps
module dsw_words_asserts
    import dsw_pkg::*;
(
    // Clock and reset
    input wire logic               clock,
    input wire logic               rst,
    // Exchange
    input wire logic [9:0]         telegram_select,
    input wire logic               exchange_strobe,
    input wire logic [15:0]        drive_command_word_three_in,
    input wire logic [15:0]        drive_status_word_one,
    input wire logic               status_valid,
    // Drive state and decoded outputs
    input wire dsw_flags_t         drive_flags,
    input wire logic signed [15:0] speed_setpoint,
    input wire logic signed [15:0] speed_actual,
    input wire logic [15:0]        speed_tolerance,
    input wire logic signed [15:0] compare_speed,
    input wire dsw_cmd_t           command_out,
    input wire logic [1:0]         command_set_select
);
    dsw_flags_t         f;
    logic [15:0]        w;
    logic [15:0]        es;
    logic [11:0]        dec;
    logic signed [16:0] d;
    // Expected status bits and decoded command from live inputs
    assign f = drive_flags;
    assign w = drive_command_word_three_in;
    assign d = speed_setpoint - speed_actual;
    assign dec = {w[3:0], w[5:4], w[8], w[9], w[11], w[12], ~w[13], w[15]};
    assign es = {telegram_select == TELEGRAM_STD20 ? f.command_set_low : ~f.inverter_overload_alarm, 1'b0,
                 ~f.motor_overtemp_alarm, f.brake_open, f.current_reached | f.torque_reached,
                 speed_actual >= compare_speed, f.master_request, (d[16] ? -d : d) <= $signed({1'b0, speed_tolerance}),
                 f.alarm_active, f.lockout_active, ~f.quick_stop_active, ~f.coast_stop_active, f.fault_pending,
                 f.operation_enabled & ~f.fault_pending, f.on_command & ~f.fault_pending,
                 f.power_on & f.electronics_ready & f.pulses_locked};
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // Capture and leave conditions of telegram 350
    sequence s_take350;
        exchange_strobe && telegram_select == TELEGRAM_CMD350 && $past(telegram_select) == TELEGRAM_CMD350;
    endsequence
    sequence s_leave;
        $past(telegram_select) == TELEGRAM_CMD350 && telegram_select != TELEGRAM_CMD350;
    endsequence
    property p_valid; exchange_strobe && telegram_select != TELEGRAM_FREE |=> status_valid; endproperty
    a_valid: assert property (p_valid) else $error("status not answered");
    property p_free; status_valid |-> $past(exchange_strobe) && $past(telegram_select) != TELEGRAM_FREE; endproperty
    a_free: assert property (p_free) else $error("status answered without exchange");
    property p_hold; !(exchange_strobe && telegram_select != TELEGRAM_FREE) |=> $stable(drive_status_word_one); endproperty
    a_hold: assert property (p_hold) else $error("status word changed without exchange");
    property p_ready; status_valid |-> drive_status_word_one[2:0] == $past(es[2:0]); endproperty
    a_ready: assert property (p_ready) else $error("ready bits wrong");
    property p_fault; status_valid |-> drive_status_word_one[7:3] == $past(es[7:3]); endproperty
    a_fault: assert property (p_fault) else $error("fault and stop bits wrong");
    property p_speed; status_valid |-> drive_status_word_one[10:8] == $past(es[10:8]); endproperty
    a_speed: assert property (p_speed) else $error("speed bits wrong");
    property p_misc; status_valid |-> drive_status_word_one[13:11] == $past(es[13:11]); endproperty
    a_misc: assert property (p_misc) else $error("limit brake heat bits wrong");
    property p_b15; status_valid |-> drive_status_word_one[15] == $past(es[15]); endproperty
    a_b15: assert property (p_b15) else $error("bit 15 wrong");
    property p_cap; s_take350 |=> command_out == $past(dec); endproperty
    a_cap: assert property (p_cap) else $error("command decode wrong");
    property p_leave; s_leave |=> command_out == CMD_RESET; endproperty
    a_leave: assert property (p_leave) else $error("command not cleared on leave");
    property p_css; !$past(rst) |-> command_set_select == {command_out.command_set_high, $past(f.command_set_low)};
    endproperty
    a_css: assert property (p_css) else $error("command set select wrong");
endmodule : dsw_words_asserts
bind dsw_words dsw_words_asserts dsw_words_asserts_inst (.clock(clock), .rst(rst), .telegram_select(telegram_select),
    .exchange_strobe(exchange_strobe), .drive_command_word_three_in(drive_command_word_three_in),
    .drive_status_word_one(drive_status_word_one), .status_valid(status_valid), .drive_flags(drive_flags),
    .speed_setpoint(speed_setpoint), .speed_actual(speed_actual), .speed_tolerance(speed_tolerance),
    .compare_speed(compare_speed), .command_out(command_out), .command_set_select(command_set_select));

/* testbench/dsw_ctrl_model.sv */
`timescale 1ns/1ps
module dsw_ctrl_model (
    // Clock
    input wire logic clock,
    // Cyclic exchange towards the drive
    output logic        exchange_strobe,
    output logic [15:0] word_out
);
    // Idle until the first exchange
    initial begin
        exchange_strobe = 1'b0;
        word_out = 16'hFFFF;
    end
    // One exchange; afterwards the word is inverted so stale data is never reused
    task automatic send(input logic [15:0] w);
        @(negedge clock);
        word_out = w;
        exchange_strobe = 1'b1;
        @(negedge clock);
        exchange_strobe = 1'b0;
        word_out = ~w;
    endtask : send
endmodule : dsw_ctrl_model

/* testbench/dsw_words_tb.sv */
`timescale 1ns/1ps
module dsw_words_tb;
    import dsw_pkg::*;
    logic               clock = 1'b0;
    logic               rst = 1'b1;
    logic [9:0]         tel = TELEGRAM_RESET;
    logic               strobe;
    logic               valid;
    logic [15:0]        cw;
    logic [15:0]        sw;
    logic [15:0]        w;
    dsw_flags_t         flags = '0;
    logic signed [15:0] sp;
    logic signed [15:0] act = 16'sh0000;
    logic signed [15:0] cmp = 16'sh0001;
    logic [15:0]        tol = 16'h0000;
    dsw_cmd_t           cmd;
    logic [1:0]         css;
    int                 miscompares = 0;
    int                 total_checks = 0;
    int                 cycles = 0;
    dsw_words dsw_words_inst (.clock(clock), .rst(rst), .telegram_select(tel), .exchange_strobe(strobe),
        .drive_command_word_three_in(cw), .drive_status_word_one(sw), .status_valid(valid), .drive_flags(flags),
        .speed_setpoint(sp), .speed_actual(act), .speed_tolerance(tol), .compare_speed(cmp),
        .command_out(cmd), .command_set_select(css));
    dsw_ctrl_model dsw_ctrl_model_inst (.clock(clock), .exchange_strobe(strobe), .word_out(cw));
    // Clock and cycle ceiling
    always #2 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict
    // Expected status word; e holds bits 14, 10 and 8
    function automatic logic [15:0] st(input dsw_flags_t f, input logic [2:0] e, input logic b15);
        return {b15, e[2], ~f.motor_overtemp_alarm, f.brake_open, f.current_reached | f.torque_reached, e[1],
                f.master_request, e[0], f.alarm_active, f.lockout_active, ~f.quick_stop_active, ~f.coast_stop_active,
                f.fault_pending, f.operation_enabled & ~f.fault_pending, f.on_command & ~f.fault_pending,
                f.power_on & f.electronics_ready & f.pulses_locked};
    endfunction : st
    // One exchange with given speeds and expected speed bits
    task automatic spd(input logic signed [15:0] s, a, input logic [15:0] t, input logic signed [15:0] c,
                       input logic [2:0] e);
        sp = s;
        act = a;
        tol = t;
        cmp = c;
        dsw_ctrl_model_inst.send(16'h0000);
        check(sw, st(flags, e, 1'b1));
    endtask : spd
    // Main sequence
    initial begin
        sp = 16'sh0000;
        repeat (3) @(negedge clock);
        rst = 1'b0;
        for (int i = 0; i < 18; i++) begin
            flags = dsw_flags_t'(17'h1 << i);
            dsw_ctrl_model_inst.send(16'h0000);
            check({15'h0, valid}, 16'h0001);
            check(sw, st(flags, 3'b001, ~flags.inverter_overload_alarm));
        end
        tel = TELEGRAM_STD20;
        flags.command_set_low = 1'b1;
        dsw_ctrl_model_inst.send(16'h0000);
        check(sw, st(flags, 3'b001, 1'b1));
        check({14'h0, css}, 16'h0001);
        tel = TELEGRAM_RESET;
        flags = '0;
        spd(16'sd100, 16'sd90, 16'd10, 16'sd90, 3'b111);
        spd(16'sd100, 16'sd90, 16'd9, 16'sd91, 3'b100);
        spd(-16'sd3, 16'sd0, 16'd2, 16'sd0, 3'b110);
        spd(-16'sd3, -16'sd5, 16'd2, -16'sd4, 3'b001);
        tel = TELEGRAM_FREE;
        flags.fault_pending = 1'b1;
        dsw_ctrl_model_inst.send(16'h0000);
        check({15'h0, valid}, 16'h0000);
        check(sw, st(dsw_flags_t'(17'h0), 3'b001, 1'b1));
        tel = TELEGRAM_CMD350;
        for (int i = 0; i < 17; i++) begin
            w = 16'h0001 << i;
            dsw_ctrl_model_inst.send(w);
            check({4'h0, cmd}, {4'h0, w[3:0], w[5:4], w[8], w[9], w[11], w[12], ~w[13], w[15]});
            check({14'h0, css}, {14'h0, w[15], 1'b0});
        end
        dsw_ctrl_model_inst.send(16'h8000);
        tel = TELEGRAM_STD20;
        repeat (2) @(negedge clock);
        check({4'h0, cmd}, {4'h0, CMD_RESET});
        dsw_ctrl_model_inst.send(16'h1F3F);
        check({4'h0, cmd}, {4'h0, CMD_RESET});
        give_verdict();
    end
endmodule : dsw_words_tb
